// ===== hdl/iowd_defines.vh
/*
 * Constants for the I/O mapped watchdog with battery status: port addresses,
 * control field positions, reset values, timeout table and timing counts.
 * Assumes an 8-bit host I/O port bus with 16-bit port addresses and a
 * 200 MHz system clock.
 */
`ifndef IOWD_DEFINES_VH
`define IOWD_DEFINES_VH

// ----------------------------------------------------------------------
// Port addresses
// ----------------------------------------------------------------------
`define IOWD_ADDR_CONTROL      16'h0062
`define IOWD_ADDR_RESTART      16'h0066
`define IOWD_ADDR_BATTERY      16'h050C

// ----------------------------------------------------------------------
// Control register fields and values
// ----------------------------------------------------------------------
`define IOWD_BIT_ENABLE        0
`define IOWD_BIT_MODE          1
`define IOWD_BIT_SELECT        2
`define IOWD_TMO_LSB           3
`define IOWD_TMO_MSB           5
`define IOWD_BIT_LAMP          6
`define IOWD_BIT_ERROR         7
`define IOWD_CONTROL_RESET     8'h00
`define IOWD_RESTART_RDATA     8'h00
`define IOWD_UNMAPPED_RDATA    8'h00

// ----------------------------------------------------------------------
// Battery condition codes, placed in bits 7:6
// ----------------------------------------------------------------------
`define IOWD_BATT_LSB          6
`define IOWD_BATT_OK           2'h0
`define IOWD_BATT_LOW          2'h1
`define IOWD_BATT_EMPTY        2'h3

// ----------------------------------------------------------------------
// Timeout table: standard range in ms, long range in s
// ----------------------------------------------------------------------
`define IOWD_STD_MS_0          16'd94
`define IOWD_STD_MS_1          16'd210
`define IOWD_STD_MS_2          16'd340
`define IOWD_STD_MS_3          16'd460
`define IOWD_STD_MS_4          16'd590
`define IOWD_STD_MS_5          16'd710
`define IOWD_STD_MS_6          16'd840
`define IOWD_STD_MS_7          16'd960
`define IOWD_LONG_S_0          16'd2
`define IOWD_LONG_S_1          16'd4
`define IOWD_LONG_S_2          16'd6
`define IOWD_LONG_S_3          16'd8
`define IOWD_LONG_S_4          16'd16
`define IOWD_LONG_S_5          16'd32
`define IOWD_LONG_S_6          16'd48
`define IOWD_LONG_S_7          16'd64
`define IOWD_MS_PER_S          16'd1000

// ----------------------------------------------------------------------
// Timing: one millisecond tick derived from the clock rate
// ----------------------------------------------------------------------
`define IOWD_CLK_MHZ           18'd200
`define IOWD_TICK_US           18'd1000
`define IOWD_TICK_CYCLES       (`IOWD_TICK_US * `IOWD_CLK_MHZ)

`endif

// ===== hdl/iowd_battery_monitor.v
/*
 * Battery condition monitor: turns the two battery comparator levels into
 * the two-bit condition code shown in the battery status register.
 * Assumes both levels are synchronous to i_clock; empty implies low.
 */
`timescale 1ns/100ps
`include "iowd_defines.vh"

module iowd_battery_monitor (
    input  wire       i_clock,
    input  wire       i_rstn,
    input  wire       i_battery_low,
    input  wire       i_battery_empty,
    output reg  [1:0] o_condition
);

    // ------------------------------------------------------------------
    // Sampling and filter
    // ------------------------------------------------------------------
    reg  [1:0] sample;
    wire [1:0] next_sample;

    // Empty wins over low so a failing cell never reads as merely low
    assign next_sample = i_battery_empty ? `IOWD_BATT_EMPTY :
                         i_battery_low   ? `IOWD_BATT_LOW   : `IOWD_BATT_OK;

    // Two equal samples are needed, so a comparator edge cannot flicker
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            sample      <= `IOWD_BATT_OK;
            o_condition <= `IOWD_BATT_OK;
        end else begin
            sample <= next_sample;
            if (sample == next_sample) begin
                o_condition <= sample;
            end
        end
    end

endmodule

// ===== hdl/iowd_timeout_counter.v
/*
 * Timeout counter: millisecond prescaler plus a millisecond count that
 * pulses o_expired once when the latched limit is reached.
 * Assumes i_limit_ms is at least 1 and stable in the cycle of i_load.
 */
`timescale 1ns/100ps
`include "iowd_defines.vh"

module iowd_timeout_counter #(
    parameter [17:0] P_TICK_CYCLES = `IOWD_TICK_CYCLES
) (
    input  wire        i_clock,
    input  wire        i_rstn,
    input  wire        i_load,
    input  wire        i_run,
    input  wire [15:0] i_limit_ms,
    output reg         o_expired
);

    // ------------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------------
    reg  [17:0] prescale;
    reg  [15:0] elapsed_ms;
    reg  [15:0] limit_ms;
    reg         done;
    wire        tick;
    wire [15:0] last_ms;

    assign tick    = (prescale == (P_TICK_CYCLES - 18'h00001));
    assign last_ms = limit_ms - 16'h0001;

    // Limit is latched on load only, so edits made while running wait
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            prescale   <= 18'h00000;
            elapsed_ms <= 16'h0000;
            limit_ms   <= 16'hFFFF;
            done       <= 1'b0;
            o_expired  <= 1'b0;
        end else if (i_load) begin
            prescale   <= 18'h00000;
            elapsed_ms <= 16'h0000;
            limit_ms   <= i_limit_ms;
            done       <= 1'b0;
            o_expired  <= 1'b0;
        end else begin
            o_expired <= 1'b0;
            if (i_run && !done) begin
                if (tick) begin
                    prescale <= 18'h00000;
                    if (elapsed_ms == last_ms) begin
                        done      <= 1'b1;
                        o_expired <= 1'b1;
                    end else begin
                        elapsed_ms <= elapsed_ms + 16'h0001;
                    end
                end else begin
                    prescale <= prescale + 18'h00001;
                end
            end
        end
    end

endmodule

// ===== hdl/iowd_top.v
/*
 * I/O mapped watchdog with battery status: control register, restart port,
 * battery status port, supervision state machine and alarm lamp output.
 * Assumes a host I/O bus whose read and write strobes last one clock and
 * are synchronous to i_clock; one strobe is answered before the next.
 */
`timescale 1ns/100ps
`include "iowd_defines.vh"

module iowd_top #(
    parameter [17:0] P_TICK_CYCLES = `IOWD_TICK_CYCLES
) (
    input  wire        i_clock,
    input  wire        i_rstn,
    input  wire [15:0] i_io_addr,
    input  wire        i_io_rd,
    input  wire        i_io_wr,
    input  wire [7:0]  i_io_wdata,
    output reg  [7:0]  o_io_rdata,
    output reg         o_io_ack,
    input  wire        i_battery_low,
    input  wire        i_battery_empty,
    output reg         o_alarm_lamp,
    output reg         o_timeout_error
);

    // ------------------------------------------------------------------
    // Supervision states
    // ------------------------------------------------------------------
    localparam [2:0] ST_OFF  = 3'b001;
    localparam [2:0] ST_RUN  = 3'b010;
    localparam [2:0] ST_TRIP = 3'b100;

    // ------------------------------------------------------------------
    // Timeout lookup
    // ------------------------------------------------------------------
    function [15:0] timeout_ms;
        input       long_range;
        input [2:0] code;
        reg   [15:0] seconds;
        begin
            seconds    = 16'h0000;
            timeout_ms = 16'h0000;
            case (code)
                3'h0: begin
                    seconds    = `IOWD_LONG_S_0;
                    timeout_ms = `IOWD_STD_MS_0;
                end
                3'h1: begin
                    seconds    = `IOWD_LONG_S_1;
                    timeout_ms = `IOWD_STD_MS_1;
                end
                3'h2: begin
                    seconds    = `IOWD_LONG_S_2;
                    timeout_ms = `IOWD_STD_MS_2;
                end
                3'h3: begin
                    seconds    = `IOWD_LONG_S_3;
                    timeout_ms = `IOWD_STD_MS_3;
                end
                3'h4: begin
                    seconds    = `IOWD_LONG_S_4;
                    timeout_ms = `IOWD_STD_MS_4;
                end
                3'h5: begin
                    seconds    = `IOWD_LONG_S_5;
                    timeout_ms = `IOWD_STD_MS_5;
                end
                3'h6: begin
                    seconds    = `IOWD_LONG_S_6;
                    timeout_ms = `IOWD_STD_MS_6;
                end
                default: begin
                    seconds    = `IOWD_LONG_S_7;
                    timeout_ms = `IOWD_STD_MS_7;
                end
            endcase
            // Largest long value is 64000 ms, which still fits 16 bits
            if (long_range) begin
                timeout_ms = seconds * `IOWD_MS_PER_S;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire hit_control;
    wire hit_restart;
    wire hit_battery;
    wire write_control;
    wire read_restart;

    assign hit_control   = (i_io_addr == `IOWD_ADDR_CONTROL);
    assign hit_restart   = (i_io_addr == `IOWD_ADDR_RESTART);
    assign hit_battery   = (i_io_addr == `IOWD_ADDR_BATTERY);
    assign write_control = i_io_wr && hit_control;
    assign read_restart  = i_io_rd && hit_restart;

    // ------------------------------------------------------------------
    // Control register state
    // ------------------------------------------------------------------
    reg        timer_enable_bit;
    reg        long_mode;
    reg        restart_select;
    reg  [2:0] timeout_code;
    reg        lamp_bit;
    reg        error_flag;
    reg  [2:0] state;
    reg  [2:0] next_state;
    reg        next_error_flag;
    reg        counter_load;
    wire       counter_run;
    wire       expired;
    wire       restart_event;
    wire [1:0] battery_condition;
    wire [7:0] control_value;
    wire [15:0] selected_ms;

    // Reserved select value leaves the restart port inert
    assign restart_event = read_restart && restart_select;

    assign control_value = {error_flag, lamp_bit, timeout_code,
                            restart_select, long_mode, timer_enable_bit};

    assign selected_ms = timeout_ms(long_mode, timeout_code);

    assign counter_run = (state == ST_RUN);

    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            timer_enable_bit <= 1'b0;
            long_mode        <= 1'b0;
            restart_select   <= 1'b0;
            timeout_code     <= 3'h0;
            lamp_bit         <= 1'b0;
        end else if (write_control) begin
            timer_enable_bit <= i_io_wdata[`IOWD_BIT_ENABLE];
            long_mode        <= i_io_wdata[`IOWD_BIT_MODE];
            restart_select   <= i_io_wdata[`IOWD_BIT_SELECT];
            timeout_code     <= i_io_wdata[`IOWD_TMO_MSB:`IOWD_TMO_LSB];
            lamp_bit         <= i_io_wdata[`IOWD_BIT_LAMP];
        end
    end

    // ------------------------------------------------------------------
    // Error flag
    // ------------------------------------------------------------------
    // An expiry in the very cycle of a clearing write still sticks
    always @* begin
        next_error_flag = error_flag;
        if (write_control && i_io_wdata[`IOWD_BIT_ERROR]) begin
            next_error_flag = 1'b0;
        end
        if (expired && (state == ST_RUN)) begin
            next_error_flag = 1'b1;
        end
    end

    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            error_flag <= 1'b0;
        end else begin
            error_flag <= next_error_flag;
        end
    end

    // ------------------------------------------------------------------
    // Supervision state machine
    // ------------------------------------------------------------------
    // The limit is sampled only when the count is (re)loaded, so edits to
    // range or code during a run take effect at the next restart or enable
    always @* begin
        next_state   = state;
        counter_load = 1'b0;
        case (state)
            ST_OFF: begin
                if (timer_enable_bit) begin
                    next_state   = ST_RUN;
                    counter_load = 1'b1;
                end
            end
            ST_RUN: begin
                if (!timer_enable_bit) begin
                    next_state = ST_OFF;
                end else if (restart_event) begin
                    counter_load = 1'b1;
                end else if (expired) begin
                    next_state = ST_TRIP;
                end
            end
            ST_TRIP: begin
                if (!timer_enable_bit) begin
                    next_state = ST_OFF;
                end else if (restart_event) begin
                    next_state   = ST_RUN;
                    counter_load = 1'b1;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Timeout counter and battery monitor
    // ------------------------------------------------------------------
    iowd_timeout_counter #(
        .P_TICK_CYCLES (P_TICK_CYCLES)
    ) u_counter (
        .i_clock    (i_clock),
        .i_rstn     (i_rstn),
        .i_load     (counter_load),
        .i_run      (counter_run),
        .i_limit_ms (selected_ms),
        .o_expired  (expired)
    );

    iowd_battery_monitor u_battery (
        .i_clock         (i_clock),
        .i_rstn          (i_rstn),
        .i_battery_low   (i_battery_low),
        .i_battery_empty (i_battery_empty),
        .o_condition     (battery_condition)
    );

    // ------------------------------------------------------------------
    // Read path and acknowledge
    // ------------------------------------------------------------------
    // Read data is the value before any write of the same cycle; writes to
    // the battery or restart ports are acknowledged and have no effect
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_io_rdata <= 8'h00;
            o_io_ack   <= 1'b0;
        end else begin
            o_io_ack <= i_io_rd || i_io_wr;
            if (i_io_rd) begin
                if (hit_control) begin
                    o_io_rdata <= control_value;
                end else if (hit_restart) begin
                    o_io_rdata <= `IOWD_RESTART_RDATA;
                end else if (hit_battery) begin
                    o_io_rdata <= {battery_condition, 6'h00};
                end else begin
                    o_io_rdata <= `IOWD_UNMAPPED_RDATA;
                end
            end else begin
                o_io_rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // Lamp and error outputs
    // ------------------------------------------------------------------
    // Lamp is lit by software or by a pending expiry; clearing bit 7
    // therefore also darkens a lamp that only the alarm had lit
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_alarm_lamp    <= 1'b0;
            o_timeout_error <= 1'b0;
        end else begin
            o_alarm_lamp    <= lamp_bit || error_flag;
            o_timeout_error <= error_flag;
        end
    end

endmodule

// ===== testbench/iowd_monitor.sv
/*
 * Checker for the I/O mapped watchdog: port bus answers, read data,
 * lamp and error flag behaviour, seen only at the top module's ports.
 * Assumes one clock, asynchronous active-low reset, bound to iowd_top.
 */
`timescale 1ns/100ps

module iowd_monitor #(
    parameter [17:0] P_TICK_CYCLES = 18'd4
) (
    input wire        i_clock,
    input wire        i_rstn,
    input wire [15:0] i_io_addr,
    input wire        i_io_rd,
    input wire        i_io_wr,
    input wire [7:0]  i_io_wdata,
    input wire [7:0]  o_io_rdata,
    input wire        o_io_ack,
    input wire        i_battery_low,
    input wire        i_battery_empty,
    input wire        o_alarm_lamp,
    input wire        o_timeout_error
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    wire ctl_wr    = i_io_wr && (i_io_addr == 16'h0062);
    wire clear_req = ctl_wr && i_io_wdata[7];

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    ack_follows_strobe_a:
        assert property ((i_io_rd || i_io_wr) |=> o_io_ack)
        else $error("no answer one cycle after a strobe");
    ack_needs_strobe_a:
        assert property (o_io_ack |-> $past(i_io_rd) || $past(i_io_wr))
        else $error("answer without a strobe");
    rdata_quiet_a:
        assert property ((o_io_rdata != 8'h00) |-> $past(i_io_rd))
        else $error("read data not zero outside a read answer");
    restart_data_a:
        assert property ((i_io_rd && i_io_addr == 16'h0066) |=> o_io_rdata == 8'h00)
        else $error("restart read data not zero");
    battery_layout_a:
        assert property ((i_io_rd && i_io_addr == 16'h050C) |=>
            (o_io_rdata[5:0] == 6'h00) && (o_io_rdata[7:6] != 2'h2))
        else $error("battery read outside the two-level code set");
    lamp_on_write_a:
        assert property ((ctl_wr && i_io_wdata[6]) |-> ##2 o_alarm_lamp)
        else $error("lamp not lit after writing bit 6");
    error_lamp_a:
        assert property (o_timeout_error |-> o_alarm_lamp)
        else $error("error flag up with lamp dark");
    error_clear_cause_a:
        assert property ($fell(o_timeout_error) |-> $past(clear_req, 2))
        else $error("error flag dropped without a clearing write");
    error_bit_read_a:
        assert property ((i_io_rd && i_io_addr == 16'h0062) |=>
            o_io_rdata[7] == o_timeout_error)
        else $error("bit 7 read back differs from error flag");

    // ------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------
    expiry_c: cover property ($rose(o_timeout_error));
    clear_c: cover property ($fell(o_timeout_error));
    restart_c: cover property (i_io_rd && i_io_addr == 16'h0066);
endmodule

bind iowd_top iowd_monitor #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_monitor (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_io_addr(i_io_addr), .i_io_rd(i_io_rd),
    .i_io_wr(i_io_wr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .o_io_ack(o_io_ack), .i_battery_low(i_battery_low),
    .i_battery_empty(i_battery_empty), .o_alarm_lamp(o_alarm_lamp),
    .o_timeout_error(o_timeout_error));

// ===== testbench/tb_io_mapped_watchdog_with_battery_status.sv
/*
 * Self-checking bench for the I/O mapped watchdog: register access,
 * battery status, timeout table, restart and error clearing.
 * Assumes iowd_top with a short millisecond tick of 4 clocks.
 */
`timescale 1ns/100ps

module tb_io_mapped_watchdog_with_battery_status;
    // Short tick keeps the 2 s and 4 s codes affordable; from 32 s up a code stays out of reach
    localparam int TICK = 4;
    logic        i_clock;
    logic        i_rstn;
    logic        i_io_rd;
    logic        i_io_wr;
    logic [15:0] i_io_addr;
    logic [7:0]  i_io_wdata;
    logic        i_battery_low;
    logic        i_battery_empty;
    wire  [7:0]  o_io_rdata;
    wire         o_io_ack;
    wire         o_alarm_lamp;
    wire         o_timeout_error;
    int          n_errors;
    int          total_checks;
    int          cycle_count;
    int          n;
    logic [7:0]  rd_val;
    logic [7:0]  ctl;
    int          std_ms [8] = '{94, 210, 340, 460, 590, 710, 840, 960};
    int          long_s [8] = '{2, 4, 6, 8, 16, 32, 48, 64};

    iowd_top #(.P_TICK_CYCLES(18'd4)) DUT (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_io_addr(i_io_addr), .i_io_rd(i_io_rd),
        .i_io_wr(i_io_wr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
        .o_io_ack(o_io_ack), .i_battery_low(i_battery_low),
        .i_battery_empty(i_battery_empty), .o_alarm_lamp(o_alarm_lamp),
        .o_timeout_error(o_timeout_error));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One strobe; the answer is taken just after the taking edge
    task automatic io_cycle(input logic rd, input logic [15:0] addr, input logic [7:0] data);
        @(posedge i_clock);
        #1;
        i_io_rd = rd;
        i_io_wr = !rd;
        i_io_addr = addr;
        i_io_wdata = data;
        @(posedge i_clock);
        #1;
        i_io_rd = 1'b0;
        i_io_wr = 1'b0;
        rd_val = o_io_rdata;
        check({7'h00, o_io_ack}, 8'h01, "ack");
    endtask

    task automatic io_rd(input logic [15:0] addr, input logic [7:0] exp, input string what);
        io_cycle(1'b1, addr, 8'h00);
        check(rd_val, exp, what);
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge i_clock);
        #1;
    endtask

    // Expiry expected lim+2 edges after a restart's taking edge, lim+3 after an enabling write's
    task automatic wait_expiry(input int lim);
        n = 0;
        while (o_timeout_error !== 1'b1 && n < lim + 10) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        total_checks++;
        if (n < lim || n > lim + 3) begin
            n_errors++;
            $display("MISMATCH at %0t: expiry after %0d expected %0d", $time, n, lim + 2);
        end
    endtask

    task automatic wrap_up;
        $display("Checks: %0d, mismatches: %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock and run limit
    // ------------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    initial begin
        cycle_count = 0;
        forever begin
            @(posedge i_clock);
            cycle_count++;
            if (cycle_count == 80000) begin
                n_errors++;
                $display("MISMATCH at %0t: run did not finish", $time);
                wrap_up();
            end
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        n_errors = 0;
        total_checks = 0;
        i_rstn = 1'b0;
        i_io_rd = 1'b0;
        i_io_wr = 1'b0;
        i_io_addr = 16'h0000;
        i_io_wdata = 8'h00;
        i_battery_low = 1'b0;
        i_battery_empty = 1'b0;
        idle(10);
        i_rstn = 1'b1;
        io_rd(16'h0062, 8'h00, "control after reset");
        io_rd(16'h0063, 8'h00, "unmapped read");
        io_cycle(1'b0, 16'h0062, 8'h7A);
        io_rd(16'h0062, 8'h7A, "control read back");
        check({7'h00, o_alarm_lamp}, 8'h01, "lamp on");
        io_cycle(1'b0, 16'h0062, 8'h04);
        idle(1);
        check({7'h00, o_alarm_lamp}, 8'h00, "lamp off");
        idle(500);
        check({7'h00, o_timeout_error}, 8'h00, "disabled stays quiet");
        // Battery levels, then a write that must not stick
        for (int k = 0; k < 3; k++) begin
            i_battery_low = (k > 0);
            i_battery_empty = (k == 2);
            idle(4);
            io_rd(16'h050C, (k == 0) ? 8'h00 : (k == 1) ? 8'h40 : 8'hC0, "battery");
        end
        io_cycle(1'b0, 16'h050C, 8'h00);
        io_rd(16'h050C, 8'hC0, "battery after write");
        // Timeout table: all standard codes and two long ones
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < (m ? 2 : 8); c++) begin
                ctl = {2'b00, 3'(c), 1'b1, 1'(m), 1'b1};
                io_cycle(1'b0, 16'h0062, ctl);
                wait_expiry(m ? long_s[c] * 1000 * TICK : std_ms[c] * TICK);
                check({7'h00, o_alarm_lamp}, 8'h01, "lamp at alarm");
                io_rd(16'h0062, ctl | 8'h80, "error bit");
                io_cycle(1'b0, 16'h0062, ctl);
                idle(2);
                check({7'h00, o_timeout_error}, 8'h01, "zero write keeps error");
                io_cycle(1'b0, 16'h0062, 8'h84);
                idle(2);
                check({6'h00, o_timeout_error, o_alarm_lamp}, 8'h00, "cleared");
            end
        end
        // Restarts hold off expiry; the last one starts a full count
        io_cycle(1'b0, 16'h0062, 8'h05);
        repeat (4) begin
            idle(300);
            io_rd(16'h0066, 8'h00, "restart data");
            check({7'h00, o_timeout_error}, 8'h00, "restart keeps alive");
        end
        wait_expiry(376);
        io_cycle(1'b0, 16'h0062, 8'h84);
        // Select bit clear: the read must not restart
        io_cycle(1'b0, 16'h0062, 8'h01);
        idle(200);
        io_rd(16'h0066, 8'h00, "reserved restart");
        wait_expiry(174);
        io_cycle(1'b0, 16'h0062, 8'h84);
        // New code written while running waits for the next restart
        io_cycle(1'b0, 16'h0062, 8'h05);
        io_cycle(1'b0, 16'h0062, 8'h3D);
        wait_expiry(374);
        io_cycle(1'b0, 16'h0062, 8'hBD);
        idle(3);
        check({7'h00, o_timeout_error}, 8'h00, "cleared while enabled");
        io_rd(16'h0066, 8'h00, "restart after change");
        wait_expiry(960 * TICK);
        wrap_up();
    end
endmodule
